//--- rtl/dsrp_readback_port.sv
`timescale 1ns/1ns
// Operation
// - id header shown in registers twenty to twentythree
// - combined layout: flag high nibble, head low
// - separate layout: whole byte is head number
// - buffer port read returns byte, then requests refill
// - no dma answer sets overrun and summary
// - trigger read pulses group strobe with byte
// - strobe trailing edge starts channel 0 refill
// - plain buffer read refills without strobing peripheral
// - loop counter read live, loads, decrements
// - force index read pulses internal index
// - force reset read aborts, keeps status
// - value readback shows indexed format value byte
// - count readback shows indexed format count byte
// - id registers update on every valid sync
// - separate layout puts fifth byte in flag register
module dsrp_readback_port #(
   parameter int DATA_W     = 8,                       // byte width of all registers
   parameter int FMT_DEPTH  = 16,                      // format ram entries
   parameter int IDX_W      = 4,                       // format ram index width
   parameter int WINDOW_CYC = dsrp_pkg::DMA_WINDOW_CYC // dma answer window in cycles
) (
   // clock and reset
   input  wire logic              core_clk,
   input  wire logic              srst,
   // processor read side, pins
   input  wire logic              io_read_strobe_n,
   input  wire logic [7:0]        reg_addr,
   output logic      [DATA_W-1:0] proc_addr_data_bus_o,
   output logic                   proc_addr_data_bus_oe,
   output logic                   group_write_strobe_n,
   // dma channel 0, pins
   output logic                   dma_ch0_request,
   input  wire logic              dma_ch0_acknowledge,
   input  wire logic [DATA_W-1:0] dma_data,
   // configuration from the write side
   input  wire logic [7:0]        header_format_config,
   input  wire logic [IDX_W-1:0]  format_ram_index,
   input  wire logic              fmt_wr_en,
   input  wire logic [IDX_W-1:0]  fmt_wr_index,
   input  wire logic [DATA_W-1:0] fmt_wr_value,
   input  wire logic [DATA_W-1:0] fmt_wr_count,
   // sequencer events
   input  wire logic              id_sync_valid,
   input  wire logic [DATA_W-1:0] id_byte0,
   input  wire logic [DATA_W-1:0] id_byte1,
   input  wire logic [DATA_W-1:0] id_byte2,
   input  wire logic [DATA_W-1:0] id_byte3,
   input  wire logic [DATA_W-1:0] id_byte4,
   input  wire logic              loop_load,
   input  wire logic [DATA_W-1:0] loop_load_value,
   input  wire logic              loop_to_restart,
   // status flags
   input  wire logic              status_clear,
   output logic                   micro_mem_overrun,
   output logic                   ext_nonzero,
   // internal sequencer controls
   output logic                   force_index,
   output logic                   force_seq_reset
);

   // synchronised pins
   logic              rd_strobe_n_s;  // read strobe after two flops
   logic [7:0]        addr_s;         // register address after two flops
   logic              ack_s;          // acknowledge after two flops
   logic [DATA_W-1:0] dma_data_s;     // dma data after two flops, aligned with ack_s
   // processor read cycle
   dsrp_pkg::dsrp_rd_state_t rd_state_r;  // read cycle state
   logic [7:0]               rd_addr_r;   // address latched at strobe fall
   logic                     rd_live;     // synced strobe low inside a read
   // dma refill
   dsrp_pkg::dsrp_dma_state_t dma_state_r;  // refill state
   logic [15:0]               win_cnt_r;    // cycles left in the answer window
   logic                      refill_go;    // trailing edge of a port or trigger read
   logic                      win_expired;  // request still unanswered at window end
   // register storage
   logic [DATA_W-1:0] cyl_high_r;                 // id byte 0
   logic [DATA_W-1:0] cyl_low_r;                  // id byte 1
   logic [DATA_W-1:0] head_raw_r;                 // id byte 2 as read
   logic [DATA_W-1:0] sector_r;                   // id byte 3
   logic [DATA_W-1:0] flag_byte_r;                // id byte 4
   logic [DATA_W-1:0] buffer_r;                   // buffer read port byte
   logic [DATA_W-1:0] loop_cnt_r;                 // live loop counter
   logic [DATA_W-1:0] fmt_value_r [FMT_DEPTH];    // format ram value bytes
   logic [DATA_W-1:0] fmt_count_r [FMT_DEPTH];    // format ram count bytes
   logic [DATA_W-1:0] rd_data_nxt;                // selected read data
   logic              rd_hit;                     // latched address is one of ours

   // fixed-width window reload value
   localparam logic [15:0] WIN_LOAD = 16'(WINDOW_CYC);

   // address decode for the bus answer; numbers of other blocks stay undriven
   function automatic logic is_mapped(input logic [7:0] a);
      return a inside {dsrp_pkg::REG_PERIPH_TRIGGER, dsrp_pkg::REG_FLAG_BYTE, dsrp_pkg::REG_ID_CYL_HIGH,
                       dsrp_pkg::REG_ID_CYL_LOW, dsrp_pkg::REG_ID_HEAD_FLAG, dsrp_pkg::REG_ID_SECTOR,
                       dsrp_pkg::REG_BUFFER_PORT, dsrp_pkg::REG_LOOP_COUNT, dsrp_pkg::REG_FORCE_INDEX,
                       dsrp_pkg::REG_FORCE_RESET, dsrp_pkg::REG_FMT_VALUE, dsrp_pkg::REG_FMT_COUNT};
   endfunction : is_mapped

   // pin synchronisers; strobe and acknowledge idle at their inactive level
   dsrp_sync #(.WIDTH(1), .RST_VAL(1'b1)) u_sync_rd
      (.core_clk(core_clk), .srst(srst), .din(io_read_strobe_n), .dout(rd_strobe_n_s));
   dsrp_sync #(.WIDTH(8), .RST_VAL(8'h00)) u_sync_addr
      (.core_clk(core_clk), .srst(srst), .din(reg_addr), .dout(addr_s));
   dsrp_sync #(.WIDTH(DATA_W + 1), .RST_VAL('0)) u_sync_dma
      (.core_clk(core_clk), .srst(srst), .din({dma_ch0_acknowledge, dma_data}), .dout({ack_s, dma_data_s}));

   // read cycle: address latched at strobe fall, actions at strobe release
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         rd_state_r <= dsrp_pkg::DSRP_RD_IDLE;
         rd_addr_r  <= 8'h00;
      end
      else
      begin
         case (rd_state_r)
            dsrp_pkg::DSRP_RD_IDLE:
            begin
               if (!rd_strobe_n_s)
               begin
                  rd_addr_r  <= addr_s;
                  rd_state_r <= dsrp_pkg::DSRP_RD_ACTIVE;
               end
            end
            dsrp_pkg::DSRP_RD_ACTIVE:
            begin
               // strobe release marks the end of the read
               if (rd_strobe_n_s)
               begin
                  rd_state_r <= dsrp_pkg::DSRP_RD_END;
               end
            end
            // end state lasts one cycle; stray codes also return to idle
            default:
            begin
               rd_state_r <= dsrp_pkg::DSRP_RD_IDLE;
            end
         endcase
      end
   end

   assign rd_hit = is_mapped(rd_addr_r);
   assign rd_live = (rd_state_r == dsrp_pkg::DSRP_RD_ACTIVE) && !rd_strobe_n_s;
   // the answer window ran out with no acknowledge seen
   assign win_expired = (dma_state_r == dsrp_pkg::DSRP_DMA_REQ) && !ack_s && (win_cnt_r <= 16'h0001);

   // a refill follows both a plain port read and a trigger read
   assign refill_go = (rd_state_r == dsrp_pkg::DSRP_RD_END) &&
                      ((rd_addr_r == dsrp_pkg::REG_BUFFER_PORT) ||
                       (rd_addr_r == dsrp_pkg::REG_PERIPH_TRIGGER));

   // read data mux; live registers are re-sampled every cycle of the read
   always_comb
   begin
      rd_data_nxt = dsrp_pkg::BYTE_RST;
      case (rd_addr_r)
         dsrp_pkg::REG_ID_CYL_HIGH:    rd_data_nxt = cyl_high_r;
         dsrp_pkg::REG_ID_CYL_LOW:     rd_data_nxt = cyl_low_r;
         // byte 2 as captured: flag high nibble and head low, or all head
         dsrp_pkg::REG_ID_HEAD_FLAG:   rd_data_nxt = head_raw_r;
         dsrp_pkg::REG_ID_SECTOR:      rd_data_nxt = sector_r;
         dsrp_pkg::REG_FLAG_BYTE:      rd_data_nxt = flag_byte_r;
         dsrp_pkg::REG_BUFFER_PORT:    rd_data_nxt = buffer_r;
         dsrp_pkg::REG_PERIPH_TRIGGER: rd_data_nxt = buffer_r;
         dsrp_pkg::REG_LOOP_COUNT:     rd_data_nxt = loop_cnt_r;
         dsrp_pkg::REG_FMT_VALUE:      rd_data_nxt = fmt_value_r[format_ram_index];
         dsrp_pkg::REG_FMT_COUNT:      rd_data_nxt = fmt_count_r[format_ram_index];
         // force registers carry no information
         default:                      rd_data_nxt = dsrp_pkg::BYTE_RST;
      endcase
   end

   // bus drive only for our own registers; other numbers belong to other blocks
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         proc_addr_data_bus_o  <= dsrp_pkg::BYTE_RST;
         proc_addr_data_bus_oe <= 1'b0;
      end
      else
      begin
         proc_addr_data_bus_o  <= (rd_live && rd_hit) ? rd_data_nxt : dsrp_pkg::BYTE_RST;
         proc_addr_data_bus_oe <= rd_live && rd_hit;
      end
   end

   // group strobe and forced pulses follow the synced read strobe, a few cycles behind the pin
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         group_write_strobe_n <= 1'b1;
         force_index          <= 1'b0;
         force_seq_reset      <= 1'b0;
      end
      else
      begin
         group_write_strobe_n <= !(rd_live && (rd_addr_r == dsrp_pkg::REG_PERIPH_TRIGGER));
         force_index          <= rd_live && (rd_addr_r == dsrp_pkg::REG_FORCE_INDEX);
         force_seq_reset      <= rd_live && (rd_addr_r == dsrp_pkg::REG_FORCE_RESET);
      end
   end

   // id header capture on every valid sync, crc result not consulted
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         cyl_high_r  <= dsrp_pkg::BYTE_RST;
         cyl_low_r   <= dsrp_pkg::BYTE_RST;
         head_raw_r  <= dsrp_pkg::BYTE_RST;
         sector_r    <= dsrp_pkg::BYTE_RST;
         flag_byte_r <= dsrp_pkg::BYTE_RST;
      end
      else if (id_sync_valid)
      begin
         cyl_high_r <= id_byte0;
         cyl_low_r  <= id_byte1;
         head_raw_r <= id_byte2;
         sector_r   <= id_byte3;
         // the fifth byte only exists in the separate flag layout
         if (header_format_config[dsrp_pkg::HDR_FMT_SEL_BIT])
         begin
            flag_byte_r <= id_byte4;
         end
      end
   end

   // loop counter; the forced sequencer reset leaves it alone
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         loop_cnt_r <= dsrp_pkg::BYTE_RST;
      end
      else if (loop_load)
      begin
         loop_cnt_r <= loop_load_value;
      end
      else if (loop_to_restart)
      begin
         loop_cnt_r <= loop_cnt_r - 8'h01;
      end
   end

   // format ram storage, written from the write side
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         for (int i = 0; i < FMT_DEPTH; i++)
         begin
            fmt_value_r[i] <= dsrp_pkg::BYTE_RST;
            fmt_count_r[i] <= dsrp_pkg::BYTE_RST;
         end
      end
      else if (fmt_wr_en)
      begin
         fmt_value_r[fmt_wr_index] <= fmt_wr_value;
         fmt_count_r[fmt_wr_index] <= fmt_wr_count;
      end
   end

   // channel 0 refill; a read during a running refill starts no second one
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         dma_state_r     <= dsrp_pkg::DSRP_DMA_IDLE;
         dma_ch0_request <= 1'b0;
         win_cnt_r       <= 16'h0000;
      end
      else
      begin
         case (dma_state_r)
            dsrp_pkg::DSRP_DMA_IDLE:
            begin
               if (refill_go)
               begin
                  dma_ch0_request <= 1'b1;
                  win_cnt_r       <= WIN_LOAD;
                  dma_state_r     <= dsrp_pkg::DSRP_DMA_REQ;
               end
            end
            dsrp_pkg::DSRP_DMA_REQ:
            begin
               if (ack_s)
               begin
                  dma_ch0_request <= 1'b0;
                  dma_state_r     <= dsrp_pkg::DSRP_DMA_DONE;
               end
               else if (win_cnt_r <= 16'h0001)
               begin
                  // window over: give up, the overrun flag reports it
                  dma_ch0_request <= 1'b0;
                  dma_state_r     <= dsrp_pkg::DSRP_DMA_IDLE;
               end
               else
               begin
                  win_cnt_r <= win_cnt_r - 16'h0001;
               end
            end
            dsrp_pkg::DSRP_DMA_DONE:
            begin
               // wait for acknowledge to fall so one answer is not taken twice
               if (!ack_s)
               begin
                  dma_state_r <= dsrp_pkg::DSRP_DMA_IDLE;
               end
            end
            default:
            begin
               dma_ch0_request <= 1'b0;
               dma_state_r     <= dsrp_pkg::DSRP_DMA_IDLE;
            end
         endcase
      end
   end

   // buffer port byte taken with the acknowledge
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         buffer_r <= dsrp_pkg::BYTE_RST;
      end
      else if ((dma_state_r == dsrp_pkg::DSRP_DMA_REQ) && ack_s)
      begin
         buffer_r <= dma_data_s;
      end
   end

   // overrun flags; a timeout in the clearing cycle still sets them
   always_ff @(posedge core_clk)
   begin
      if (srst || (status_clear && !win_expired))
      begin
         micro_mem_overrun <= 1'b0;
         ext_nonzero       <= 1'b0;
      end
      else if (win_expired)
      begin
         micro_mem_overrun <= 1'b1;
         ext_nonzero       <= 1'b1;
      end
   end

endmodule : dsrp_readback_port

//--- include/dsrp_pkg.sv
// shared constants of the disk sequencer readback port
package dsrp_pkg;

   // register numbers as seen on the register address pins
   localparam logic [7:0] REG_PERIPH_TRIGGER = 8'h0b;  // 11, peripheral_transfer_trigger
   localparam logic [7:0] REG_FLAG_BYTE      = 8'h13;  // 19, flag_byte_register
   localparam logic [7:0] REG_ID_CYL_HIGH    = 8'h14;  // 20, id_cylinder_high
   localparam logic [7:0] REG_ID_CYL_LOW     = 8'h15;  // 21, id_cylinder_low
   localparam logic [7:0] REG_ID_HEAD_FLAG   = 8'h16;  // 22, id_head_flag
   localparam logic [7:0] REG_ID_SECTOR      = 8'h17;  // 23, id_sector_number
   localparam logic [7:0] REG_BUFFER_PORT    = 8'h18;  // 24, buffer_read_port
   localparam logic [7:0] REG_LOOP_COUNT     = 8'h19;  // 25, loop_count_live
   localparam logic [7:0] REG_FORCE_INDEX    = 8'h1b;  // 27, force_index_trigger
   localparam logic [7:0] REG_FORCE_RESET    = 8'h1c;  // 28, force_sequencer_reset
   localparam logic [7:0] REG_FMT_VALUE      = 8'h1e;  // 30, format_value_readback
   localparam logic [7:0] REG_FMT_COUNT      = 8'h1f;  // 31, format_count_readback

   // field positions
   localparam int HDR_FMT_SEL_BIT  = 2;   // header_format_config: 1 = separate flag byte
   localparam int EXT_MICRO_OVR    = 1;   // extended_status bit of micro memory overrun
   localparam int MAIN_EXT_NZ      = 7;   // main_status extended non-zero summary bit

   // values after reset
   localparam logic [7:0] BYTE_RST  = 8'h00;
   localparam logic [3:0] INDEX_RST = 4'h0;

   // timing: one byte time for the dma answer, clock period
   localparam int CLK_PERIOD_NS   = 10;
   localparam int DMA_WINDOW_NS   = 800;
   // a longest wait rounds down, never below one cycle
   localparam int DMA_WINDOW_CYC  = (DMA_WINDOW_NS / CLK_PERIOD_NS) < 1 ? 1 : (DMA_WINDOW_NS / CLK_PERIOD_NS);

   // dma channel 0 refill states
   typedef enum logic [1:0]
   {
      DSRP_DMA_IDLE = 2'b00,  // no refill running
      DSRP_DMA_REQ  = 2'b01,  // request raised, waiting for acknowledge
      DSRP_DMA_DONE = 2'b10   // byte taken, waiting for acknowledge to drop
   } dsrp_dma_state_t;

   // processor read cycle states
   typedef enum logic [1:0]
   {
      DSRP_RD_IDLE   = 2'b00,  // read strobe high
      DSRP_RD_ACTIVE = 2'b01,  // read strobe low, bus driven
      DSRP_RD_END    = 2'b10   // strobe just released, trailing actions
   } dsrp_rd_state_t;

endpackage : dsrp_pkg

//--- rtl/dsrp_sync.sv
`timescale 1ns/1ns
// two-stage synchroniser for pins that arrive from outside core_clk
module dsrp_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   // clock and reset
   input  wire logic             core_clk,
   input  wire logic             srst,
   // asynchronous input and its synchronised copy
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);

   logic [WIDTH-1:0] meta_r;  // first stage, read only by the second

   // both stages reset to the idle level of the pin
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         meta_r <= RST_VAL;
         dout   <= RST_VAL;
      end
      else
      begin
         meta_r <= din;
         dout   <= meta_r;
      end
   end

endmodule : dsrp_sync

//--- tb/dsrp_readback_port_asserts.sv
`timescale 1ns/1ns
// port checker, sees only top-level pins
module dsrp_readback_port_asserts #(
   parameter int DATA_W     = 8,   // byte width
   parameter int WINDOW_CYC = 80   // dma answer window
) (
   // clock and reset
   input wire logic       core_clk,
   input wire logic       srst,
   // processor side
   input wire logic       io_read_strobe_n,
   input wire logic [7:0] reg_addr,
   input wire logic       proc_addr_data_bus_oe,
   input wire logic       group_write_strobe_n,
   // dma and status
   input wire logic       dma_ch0_request,
   input wire logic       dma_ch0_acknowledge,
   input wire logic       status_clear,
   input wire logic       micro_mem_overrun,
   input wire logic       ext_nonzero,
   input wire logic       force_index,
   input wire logic       force_seq_reset
);
   // longest request, window plus synchroniser slack
   localparam int REQ_MAX = WINDOW_CYC + 4;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);
   AST_ADDR_MAPPED : assert property ($rose(proc_addr_data_bus_oe) |-> reg_addr inside {8'h0b, 8'h13, 8'h14,
      8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1b, 8'h1c, 8'h1e, 8'h1f}) else $error("bus driven for foreign address");
   AST_GRP_ONLY_TRIGGER : assert property (!group_write_strobe_n |-> proc_addr_data_bus_oe
      && reg_addr == dsrp_pkg::REG_PERIPH_TRIGGER) else $error("group strobe outside trigger read");
   AST_GRP_ON_TRIGGER : assert property ($rose(proc_addr_data_bus_oe) && reg_addr == 8'h0b |->
      !group_write_strobe_n) else $error("trigger read without group strobe");
   AST_NO_GRP_BUFFER : assert property (proc_addr_data_bus_oe && reg_addr == 8'h18 |->
      group_write_strobe_n) else $error("group strobe on buffer read");
   AST_REFILL_TRAIL : assert property ($rose(group_write_strobe_n) |-> ##[0:2] dma_ch0_request)
      else $error("no refill after group strobe");
   AST_REFILL_BUFFER : assert property ($fell(proc_addr_data_bus_oe) && reg_addr == 8'h18 |->
      ##[0:2] dma_ch0_request) else $error("no refill after buffer read");
   AST_REQ_HOLD : assert property ($rose(dma_ch0_request) |-> dma_ch0_request [*2]
      ##[0:REQ_MAX] !dma_ch0_request) else $error("request held badly");
   AST_OVERRUN_SET : assert property ($fell(dma_ch0_request) && !dma_ch0_acknowledge
      && !$past(dma_ch0_acknowledge) && !$past(dma_ch0_acknowledge, 2) |-> ##[0:2] micro_mem_overrun)
      else $error("unanswered request left overrun clear");
   AST_SUMMARY : assert property ($rose(micro_mem_overrun) |-> ##[0:1] ext_nonzero)
      else $error("summary flag missing");
   AST_STICKY : assert property (micro_mem_overrun && !status_clear |=> micro_mem_overrun)
      else $error("overrun flag lost");
   AST_FORCE_INDEX : assert property (force_index |-> reg_addr == dsrp_pkg::REG_FORCE_INDEX)
      else $error("index pulse on wrong read");
   AST_FORCE_RESET : assert property ($rose(force_seq_reset) |-> !io_read_strobe_n
      && reg_addr == dsrp_pkg::REG_FORCE_RESET) else $error("reset pulse on wrong read");
endmodule : dsrp_readback_port_asserts

bind dsrp_readback_port dsrp_readback_port_asserts #(.DATA_W(DATA_W), .WINDOW_CYC(WINDOW_CYC)) chk_u (
   .core_clk(core_clk), .srst(srst), .io_read_strobe_n(io_read_strobe_n), .reg_addr(reg_addr),
   .proc_addr_data_bus_oe(proc_addr_data_bus_oe), .group_write_strobe_n(group_write_strobe_n),
   .dma_ch0_request(dma_ch0_request), .dma_ch0_acknowledge(dma_ch0_acknowledge),
   .status_clear(status_clear), .micro_mem_overrun(micro_mem_overrun), .ext_nonzero(ext_nonzero),
   .force_index(force_index), .force_seq_reset(force_seq_reset));

//--- tb/dsrp_dma_model.sv
`timescale 1ns/1ns
// channel 0 dma controller, memory to device only
module dsrp_dma_model (
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       srst,
   // channel 0 pins
   input  wire logic       dma_ch0_request,
   output logic            dma_ch0_acknowledge,
   output logic [7:0]      dma_data,
   // bench controls
   input  wire logic       mute,        // never answer
   input  wire logic [1:0] ack_delay,   // extra cycles before acknowledge
   input  wire logic [7:0] next_byte    // memory byte to hand over
);
   logic [1:0] cnt_r;  // wait counter
   // acknowledge after delay, hold until request drops
   always_ff @(posedge core_clk)
   begin
      if (srst || !dma_ch0_request)
      begin
         dma_ch0_acknowledge <= 1'b0;
         cnt_r               <= 2'h0;
      end
      else if (!mute && !dma_ch0_acknowledge)
      begin
         if (cnt_r >= ack_delay)
            dma_ch0_acknowledge <= 1'b1;
         else
            cnt_r <= cnt_r + 2'h1;
      end
   end
   // read-memory direction; inverted byte when idle so stale data cannot pass
   assign dma_data = dma_ch0_acknowledge ? next_byte : ~next_byte;
endmodule : dsrp_dma_model

//--- tb/disk_sequencer_readback_port_bench.sv
`timescale 1ns/1ns
// bench: reads through the pins, monitor compares queued notes
module disk_sequencer_readback_port_bench;
   logic       core_clk, srst, io_read_strobe_n, proc_addr_data_bus_oe, group_write_strobe_n;
   logic [7:0] reg_addr, proc_addr_data_bus_o, header_format_config, dma_data, next_byte, loop_load_value;
   logic [7:0] id_byte0, id_byte1, id_byte2, id_byte3, id_byte4, fmt_wr_value, fmt_wr_count;
   logic [3:0] format_ram_index, fmt_wr_index;
   logic       dma_ch0_request, dma_ch0_acknowledge, fmt_wr_en, id_sync_valid, loop_load, loop_to_restart;
   logic       status_clear, micro_mem_overrun, ext_nonzero, force_index, force_seq_reset, mute, oe_d;
   logic [1:0] ack_delay;
   logic       mid_grp, mid_fidx, mid_frst;  // snapshots taken mid-read
   logic [7:0] exp_q[$];                     // expected read data
   int         failures, checks_done, seed, m;

   dsrp_readback_port #(.WINDOW_CYC(8)) dut_u (.core_clk(core_clk), .srst(srst),
      .io_read_strobe_n(io_read_strobe_n), .reg_addr(reg_addr), .proc_addr_data_bus_o(proc_addr_data_bus_o),
      .proc_addr_data_bus_oe(proc_addr_data_bus_oe), .group_write_strobe_n(group_write_strobe_n),
      .dma_ch0_request(dma_ch0_request), .dma_ch0_acknowledge(dma_ch0_acknowledge), .dma_data(dma_data),
      .header_format_config(header_format_config), .format_ram_index(format_ram_index),
      .fmt_wr_en(fmt_wr_en), .fmt_wr_index(fmt_wr_index), .fmt_wr_value(fmt_wr_value),
      .fmt_wr_count(fmt_wr_count), .id_sync_valid(id_sync_valid), .id_byte0(id_byte0), .id_byte1(id_byte1),
      .id_byte2(id_byte2), .id_byte3(id_byte3), .id_byte4(id_byte4), .loop_load(loop_load),
      .loop_load_value(loop_load_value), .loop_to_restart(loop_to_restart), .status_clear(status_clear),
      .micro_mem_overrun(micro_mem_overrun), .ext_nonzero(ext_nonzero), .force_index(force_index),
      .force_seq_reset(force_seq_reset));
   dsrp_dma_model dma_u (.core_clk(core_clk), .srst(srst), .dma_ch0_request(dma_ch0_request),
      .dma_ch0_acknowledge(dma_ch0_acknowledge), .dma_data(dma_data), .mute(mute),
      .ack_delay(ack_delay), .next_byte(next_byte));

   // 100 MHz clock
   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // one comparison, counted
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         failures++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   // verdict and end of run
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : report_and_stop

   // one processor read; long strobe, long gap so refills settle
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input bit note);
      if (note)
         exp_q.push_back(e);
      @(posedge core_clk);
      reg_addr         <= a;
      io_read_strobe_n <= 1'b0;
      repeat (5) @(posedge core_clk);
      @(negedge core_clk);
      mid_grp  = group_write_strobe_n;
      mid_fidx = force_index;
      mid_frst = force_seq_reset;
      @(posedge core_clk);
      io_read_strobe_n <= 1'b1;
      repeat (16) @(posedge core_clk);
   endtask : rd

   // monitor: each fresh bus drive consumes the oldest note
   always @(negedge core_clk)
   begin
      oe_d <= proc_addr_data_bus_oe;
      if (proc_addr_data_bus_oe === 1'b1 && oe_d !== 1'b1)
      begin
         if (exp_q.size() == 0)
            check(8'h01, 8'h00);
         else
            check(proc_addr_data_bus_o, exp_q.pop_front());
      end
   end

   // watchdog
   initial
   begin
      #100000;
      failures++;
      report_and_stop();
   end

   // main sequence
   initial
   begin
      seed = 37;
      {srst, io_read_strobe_n} = 2'b11;
      {reg_addr, header_format_config, format_ram_index, fmt_wr_en, fmt_wr_index} = '0;
      {fmt_wr_value, fmt_wr_count, id_sync_valid, id_byte0, id_byte1, id_byte2, id_byte3, id_byte4} = '0;
      {loop_load, loop_load_value, loop_to_restart, status_clear, mute, ack_delay, next_byte} = '0;
      repeat (5) @(posedge core_clk);
      srst <= 1'b0;
      @(negedge core_clk);
      check(8'({proc_addr_data_bus_oe, group_write_strobe_n, dma_ch0_request, micro_mem_overrun}), 8'h04);
      // id capture in both header layouts
      for (m = 0; m < 2; m++)
      begin
         @(posedge core_clk);
         header_format_config <= (m == 1) ? 8'h04 : 8'h00;
         {id_byte0, id_byte1, id_byte2, id_byte3, id_byte4} <= 40'({$random(seed), $random(seed)});
         id_sync_valid <= 1'b1;
         @(posedge core_clk);
         id_sync_valid <= 1'b0;
         rd(dsrp_pkg::REG_ID_CYL_HIGH, id_byte0, 1);
         rd(dsrp_pkg::REG_ID_CYL_LOW, id_byte1, 1);
         rd(dsrp_pkg::REG_ID_HEAD_FLAG, id_byte2, 1);
         rd(dsrp_pkg::REG_ID_SECTOR, id_byte3, 1);
         if (m == 1)
            rd(dsrp_pkg::REG_FLAG_BYTE, id_byte4, 1);
      end
      // format ram readback
      @(posedge core_clk);
      {fmt_wr_en, fmt_wr_index, fmt_wr_value, fmt_wr_count} <= {1'b1, 20'($random(seed))};
      @(posedge core_clk);
      fmt_wr_en        <= 1'b0;
      format_ram_index <= fmt_wr_index;
      rd(dsrp_pkg::REG_FMT_VALUE, fmt_wr_value, 1);
      rd(dsrp_pkg::REG_FMT_COUNT, fmt_wr_count, 1);
      // loop counter: load, one decrement, read three times, forced index and reset reads before the last
      @(posedge core_clk);
      loop_load       <= 1'b1;
      loop_load_value <= 8'($random(seed));
      @(posedge core_clk);
      {loop_load, loop_to_restart} <= 2'b01;
      @(posedge core_clk);
      loop_to_restart <= 1'b0;
      rd(dsrp_pkg::REG_LOOP_COUNT, loop_load_value - 8'h01, 1);
      rd(dsrp_pkg::REG_LOOP_COUNT, loop_load_value - 8'h01, 1);
      rd(dsrp_pkg::REG_FORCE_INDEX, 8'h00, 1);
      check(8'(mid_fidx), 8'h01);
      rd(dsrp_pkg::REG_FORCE_RESET, 8'h00, 1);
      check(8'(mid_frst), 8'h01);
      rd(dsrp_pkg::REG_LOOP_COUNT, loop_load_value - 8'h01, 1);
      rd(8'h1a, 8'h00, 0);
      // buffer port: stale first byte, refills, peripheral strobe
      ack_delay <= 2'($random(seed));
      next_byte <= 8'($random(seed));
      rd(dsrp_pkg::REG_BUFFER_PORT, dsrp_pkg::BYTE_RST, 1);
      check(8'(mid_grp), 8'h01);
      rd(dsrp_pkg::REG_PERIPH_TRIGGER, next_byte, 1);
      check(8'(mid_grp), 8'h00);
      for (m = 0; m < 2; m++)
      begin
         ack_delay <= 2'($random(seed));
         next_byte <= 8'($random(seed));
         mute      <= (m == 1);
         rd(dsrp_pkg::REG_BUFFER_PORT, next_byte, 1);
         @(posedge core_clk);
         next_byte <= 8'($random(seed));
      end
      // unanswered refill leaves sticky flags
      repeat (4) @(posedge core_clk);
      @(negedge core_clk);
      check(8'({micro_mem_overrun, ext_nonzero}), 8'h03);
      @(posedge core_clk);
      status_clear <= 1'b1;
      @(posedge core_clk);
      status_clear <= 1'b0;
      @(negedge core_clk);
      check(8'({micro_mem_overrun, ext_nonzero}), 8'h00);
      check(8'(exp_q.size()), 8'h00);
      report_and_stop();
   end
endmodule : disk_sequencer_readback_port_bench
